// ### src/rap_pkg.sv
// Package: constants for the two-wire register access port.
// Assumes one 40 MHz clock; bus pins are sampled as synchronous inputs.
package rap_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;

  // ****************************************
  // Chip address and register map
  // ****************************************
  localparam logic [6:0] CHIP_ADDR                     = 7'h60;
  localparam logic [7:0] ADDR_MASTER_VOLTAGE_ENABLE    = 8'h00;
  localparam logic [7:0] ADDR_FORCED_PULSE_WIDTH_SELECT = 8'h06;
  localparam logic [7:0] ADDR_PHASE0_CONTROL           = 8'h07;
  localparam logic [7:0] ADDR_PHASE1_CURRENT_LIMIT     = 8'h08;
  localparam logic [7:0] ADDR_PHASE2_CURRENT_LIMIT     = 8'h09;
  localparam logic [7:0] ADDR_PHASE3_CURRENT_LIMIT     = 8'h0a;
  localparam logic [7:0] ADDR_PHASE4_CURRENT_LIMIT     = 8'h0b;
  localparam logic [7:0] ADDR_PHASE5_CURRENT_LIMIT     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS_FLAGS_LOW         = 8'h0d;
  localparam logic [7:0] ADDR_FAULT_FLAGS              = 8'h0e;
  localparam logic [7:0] ADDR_INTERRUPT_MASK_LOW       = 8'h0f;
  localparam logic [7:0] ADDR_GENERAL_CONFIG           = 8'h10;
  localparam logic [7:0] ADDR_SOFTWARE_RESET           = 8'h11;
  localparam logic [7:0] ADDR_STARTUP_DELAY            = 8'h12;
  localparam logic [7:0] ADDR_PART_IDENTIFICATION      = 8'h18;
  localparam logic [7:0] ADDR_LIGHT_LOAD_THRESHOLDS    = 8'h19;
  localparam logic [7:0] ADDR_PHASE_SHEDDING_THRESHOLDS = 8'h1f;
  localparam logic [7:0] ADDR_LOAD_CURRENT_SELECT      = 8'h21;
  localparam logic [7:0] ADDR_LOAD_CURRENT_LOW         = 8'h22;
  localparam logic [7:0] ADDR_INTERRUPT_MASK_HIGH      = 8'h2e;

  // Storage covers the whole 6-bit address span of the map
  localparam int REG_AW      = 6;
  localparam int REG_DEPTH   = 64;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // ****************************************
  // Serial engine states
  // ****************************************
  typedef enum logic [5:0] {
    RAP_IDLE  = 6'b000001,
    RAP_RECV  = 6'b000010,
    RAP_RACK  = 6'b000100,
    RAP_SEND  = 6'b001000,
    RAP_MACK  = 6'b010000,
    RAP_SKIP  = 6'b100000
  } rap_state_t;

  typedef enum logic [1:0] {
    RAP_BYTE_ADDR = 2'h0,
    RAP_BYTE_REG  = 2'h1,
    RAP_BYTE_DATA = 2'h2
  } rap_byte_t;

endpackage : rap_pkg

// ### src/rap_regmem.sv
// Register storage: one write port, two registered read ports.
// Assumes writes from the two serial engines never collide in one cycle (arbitrated above).
`timescale 1ns/1ps
module rap_regmem import rap_pkg::*; #(
  parameter int AW    = REG_AW,
  parameter int DEPTH = REG_DEPTH
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_sync_b,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // Read ports
  input  wire logic [AW-1:0] rd_addr_a,
  output logic      [7:0]    rd_data_a_ff,
  input  wire logic [AW-1:0] rd_addr_b,
  output logic      [7:0]    rd_data_b_ff,
  // Read-only sources
  input  wire logic [7:0]    part_id,
  input  wire logic [7:0]    load_current
);

  logic [7:0] mem_ff [DEPTH];

  function automatic logic [7:0] rd_sel(input logic [AW-1:0] a, input logic [7:0] m,
                                        input logic [7:0] pid, input logic [7:0] cur);
    if (a == AW'(ADDR_PART_IDENTIFICATION)) begin
      rd_sel = pid;
    end else if (a == AW'(ADDR_LOAD_CURRENT_LOW)) begin
      rd_sel = cur;
    end else begin
      rd_sel = m;
    end
  endfunction : rd_sel

  wire logic wr_ok = wr_en && (wr_addr != AW'(ADDR_PART_IDENTIFICATION))
                     && (wr_addr != AW'(ADDR_LOAD_CURRENT_LOW));

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= REG_RESET_VALUE;
      rd_data_a_ff <= REG_RESET_VALUE;
      rd_data_b_ff <= REG_RESET_VALUE;
    end else begin
      if (wr_ok) mem_ff[wr_addr] <= wr_data;
      rd_data_a_ff <= rd_sel(rd_addr_a, mem_ff[rd_addr_a], part_id, load_current);
      rd_data_b_ff <= rd_sel(rd_addr_b, mem_ff[rd_addr_b], part_id, load_current);
    end
  end

endmodule : rap_regmem

// ### src/rap_top.sv
// Top: two independent two-wire slave engines sharing one register set.
// Assumes bus pins are synchronous to clk and clk is much faster than the bus clock.
`timescale 1ns/1ps

// ****************************************
// Serial slave engine
// ****************************************
module rap_engine import rap_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_sync_b,
  // Bus pins
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_oe,
  // Register access
  output logic                   wr_req,
  output logic      [REG_AW-1:0] reg_idx,
  output logic      [7:0]        wr_byte,
  input  wire logic              wr_grant,
  input  wire logic [7:0]        rd_byte,
  // Status
  output logic                   busy
);

  rap_state_t       state_ff, nxt_state;
  rap_byte_t        phase_ff, nxt_phase;
  logic [7:0]       shift_ff, nxt_shift;
  logic [3:0]       bit_ff, nxt_bit;
  logic [7:0]       idx_ff, nxt_idx;
  logic             rd_dir_ff, nxt_rd_dir;
  logic             scl_d_ff, sda_d_ff;
  logic             busy_ff, nxt_busy;
  logic             oe_ff, nxt_oe;
  logic             wr_pend_ff, nxt_wr_pend;
  logic [7:0]       wbyte_ff, nxt_wbyte;

  wire logic scl_rise   = scl_in && !scl_d_ff;
  wire logic scl_fall   = !scl_in && scl_d_ff;
  // Data changes while the clock is high are framing, never data
  wire logic start_seen = scl_in && scl_d_ff && sda_d_ff && !sda_in; // R2
  wire logic stop_seen  = scl_in && scl_d_ff && !sda_d_ff && sda_in; // R2
  wire logic addr_match = shift_ff[7:1] == CHIP_ADDR;                // R13

  assign sda_oe  = oe_ff;
  assign busy    = busy_ff;
  assign wr_req  = wr_pend_ff;
  assign reg_idx = idx_ff[REG_AW-1:0];
  assign wr_byte = wbyte_ff;

  always_comb begin
    nxt_state   = state_ff;
    nxt_phase   = phase_ff;
    nxt_shift   = shift_ff;
    nxt_bit     = bit_ff;
    nxt_idx     = idx_ff;
    nxt_rd_dir  = rd_dir_ff;
    nxt_busy    = busy_ff;
    nxt_oe      = oe_ff;
    nxt_wbyte   = wbyte_ff;
    nxt_wr_pend = wr_pend_ff && !wr_grant;
    if (start_seen) begin
      // Repeated start restarts address reception; index is kept for reads
      nxt_state = RAP_RECV; // R5
      nxt_phase = RAP_BYTE_ADDR;
      nxt_bit   = 4'h0;
      nxt_busy  = 1'b1; // R4
      nxt_oe    = 1'b0;
    end else if (stop_seen) begin
      nxt_state = RAP_IDLE;
      nxt_busy  = 1'b0; // R4
      nxt_oe    = 1'b0;
    end else begin
      case (state_ff)
        RAP_IDLE: begin
          nxt_oe = 1'b0;
        end
        RAP_RECV: begin
          if (scl_rise) begin
            // Eight bits, most significant first
            nxt_shift = {shift_ff[6:0], sda_in}; // R6
            nxt_bit   = bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            nxt_bit = 4'h0;
            case (phase_ff)
              RAP_BYTE_ADDR: begin
                if (addr_match) begin
                  nxt_rd_dir = shift_ff[0]; // R10
                  nxt_oe     = 1'b1;        // R7
                  nxt_state  = RAP_RACK;
                end else begin
                  nxt_state = RAP_SKIP;
                end
              end
              RAP_BYTE_REG: begin
                nxt_idx   = shift_ff; // R11
                nxt_oe    = 1'b1;     // R7
                nxt_state = RAP_RACK;
              end
              default: begin
                nxt_wbyte   = shift_ff; // R11
                nxt_wr_pend = 1'b1;     // R20
                nxt_oe      = 1'b1;     // R7
                nxt_state   = RAP_RACK;
              end
            endcase
          end
        end
        RAP_RACK: begin
          // Held low across the whole ninth clock, released after its fall except on a read, which then drives bit 7 of the register
          if (scl_fall) begin
            if (phase_ff == RAP_BYTE_DATA) begin
              nxt_idx = idx_ff + 8'h01; // R14
            end
            if (phase_ff == RAP_BYTE_ADDR && rd_dir_ff) begin
              nxt_state = RAP_SEND; // R22
              nxt_shift = rd_byte;
              nxt_oe    = !rd_byte[7];
              nxt_bit   = 4'h1;
            end else begin
              nxt_state = RAP_RECV;
              nxt_oe    = 1'b0;
              nxt_phase = (phase_ff == RAP_BYTE_ADDR) ? RAP_BYTE_REG : RAP_BYTE_DATA;
            end
          end
        end
        RAP_SEND: begin
          // Data only moves on the falling clock edge
          if (scl_fall) begin // R1
            if (bit_ff == 4'h8) begin
              nxt_oe    = 1'b0; // R22
              nxt_state = RAP_MACK;
            end else begin
              nxt_oe  = !shift_ff[3'(4'h7 - bit_ff)]; // R22
              nxt_bit = bit_ff + 4'h1;
            end
          end
        end
        RAP_MACK: begin
          if (scl_rise) begin
            // No auto-increment on reads: the same register repeats
            nxt_shift = rd_byte; // R15
            nxt_state = sda_in ? RAP_SKIP : RAP_MACK; // R9
          end else if (scl_fall) begin
            nxt_state = RAP_SEND;
            nxt_oe    = !shift_ff[7];
            nxt_bit   = 4'h1;
          end
        end
        RAP_SKIP: begin
          nxt_oe = 1'b0;
        end
        default: begin
          nxt_state = RAP_IDLE;
          nxt_oe    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_ff   <= RAP_IDLE;
      phase_ff   <= RAP_BYTE_ADDR;
      shift_ff   <= 8'h00;
      bit_ff     <= 4'h0;
      idx_ff     <= 8'h00;
      rd_dir_ff  <= 1'b0;
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
      busy_ff    <= 1'b0;
      oe_ff      <= 1'b0;
      wr_pend_ff <= 1'b0;
      wbyte_ff   <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      phase_ff   <= nxt_phase;
      shift_ff   <= nxt_shift;
      bit_ff     <= nxt_bit;
      idx_ff     <= nxt_idx;
      rd_dir_ff  <= nxt_rd_dir;
      scl_d_ff   <= scl_in;
      sda_d_ff   <= sda_in;
      busy_ff    <= nxt_busy;
      oe_ff      <= nxt_oe;
      wr_pend_ff <= nxt_wr_pend;
      wbyte_ff   <= nxt_wbyte;
    end
  end

endmodule : rap_engine

// ****************************************
// Top level
// ****************************************
// Operation
// R1: Data changes only while clock low
// R2: Detect start and stop framing
// R3: Only master makes start and stop
// R4: Busy from start until stop
// R5: Repeated start restarts address reception
// R6: Eight bits MSB first plus acknowledge
// R7: Acknowledge low through ninth clock
// R8: Master clocks and releases acknowledge bit
// R9: Master nack ends read
// R10: Address byte: seven bits, direction
// R11: Register byte then data byte
// R12: Master sets index before reading
// R13: Respond to chip address 0x60
// R14: Index advances after each written byte
// R15: No index advance on reads
// R16: Software preserves reserved bits on write
// R17: Works at 100k, 400k, 3.4M
// R18: Two independent buses reach registers
// R19: Only bus clock times transfers
// R20: Writes accepted while external reset low
// R21: All registers accessible in standby
// R22: Read shifts register out, releases ack
module rap_top import rap_pkg::*; #(
  parameter logic [7:0] PART_ID = 8'h5a  // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // System bus pins
  input  wire logic       system_bus_clock_pin,
  input  wire logic       system_bus_data_pin_in,
  output logic            system_bus_data_pin_oe,
  // Voltage scaling bus pins
  input  wire logic       scaling_bus_clock_pin,
  input  wire logic       scaling_bus_data_pin_in,
  output logic            scaling_bus_data_pin_oe,
  // Device side
  input  wire logic       external_reset_input,
  input  wire logic [7:0] load_current,
  output logic            system_bus_busy,
  output logic            voltage_scaling_bus_busy,
  output logic [7:0]      master_voltage_enable_ff
);

  logic             rst_s1_ff, rst_s2_ff;
  logic             sys_wr, vsb_wr;
  logic [REG_AW-1:0] sys_idx, vsb_idx;
  logic [7:0]       sys_wbyte, vsb_wbyte, sys_rbyte, vsb_rbyte;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // The external reset input never gates the serial path, so writes still land
  wire logic ext_reset_seen = external_reset_input; // R20

  // System bus wins a same-cycle collision; the scaling bus waits one cycle
  wire logic sys_grant = sys_wr; // R18
  wire logic vsb_grant = vsb_wr && !sys_wr;
  wire logic            mem_we    = sys_grant || vsb_grant;
  wire logic [REG_AW-1:0] mem_waddr = sys_grant ? sys_idx : vsb_idx;
  wire logic [7:0]      mem_wdata = sys_grant ? sys_wbyte : vsb_wbyte;

  // Both engines sample only their own bus clock pin, never a separate clock pin
  rap_engine u_sys (  // R19 R17
    .clk        (clk),
    .rst_sync_b (rst_s2_ff),
    .scl_in     (system_bus_clock_pin),
    .sda_in     (system_bus_data_pin_in),
    .sda_oe     (system_bus_data_pin_oe),
    .wr_req     (sys_wr),
    .reg_idx    (sys_idx),
    .wr_byte    (sys_wbyte),
    .wr_grant   (sys_grant),
    .rd_byte    (sys_rbyte),
    .busy       (system_bus_busy)
  );

  rap_engine u_vsb (  // R18
    .clk        (clk),
    .rst_sync_b (rst_s2_ff),
    .scl_in     (scaling_bus_clock_pin),
    .sda_in     (scaling_bus_data_pin_in),
    .sda_oe     (scaling_bus_data_pin_oe),
    .wr_req     (vsb_wr),
    .reg_idx    (vsb_idx),
    .wr_byte    (vsb_wbyte),
    .wr_grant   (vsb_grant),
    .rd_byte    (vsb_rbyte),
    .busy       (voltage_scaling_bus_busy)
  );

  // Every register reachable from either bus at all times
  rap_regmem u_mem (  // R21
    .clk          (clk),
    .rst_sync_b   (rst_s2_ff),
    .wr_en        (mem_we),
    .wr_addr      (mem_waddr),
    .wr_data      (mem_wdata),
    .rd_addr_a    (sys_idx),
    .rd_data_a_ff (sys_rbyte),
    .rd_addr_b    (vsb_idx),
    .rd_data_b_ff (vsb_rbyte),
    .part_id      (PART_ID),
    .load_current (load_current)
  );

  // Mirror of the enable register steering the converter
  always_ff @(posedge clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      master_voltage_enable_ff <= REG_RESET_VALUE;
    end else if (mem_we && mem_waddr == REG_AW'(ADDR_MASTER_VOLTAGE_ENABLE)
                 && !ext_reset_seen) begin
      master_voltage_enable_ff <= mem_wdata;
    end else if (mem_we && mem_waddr == REG_AW'(ADDR_MASTER_VOLTAGE_ENABLE)) begin
      master_voltage_enable_ff <= mem_wdata;
    end
  end

endmodule : rap_top

// ### verification/rap_bus_master.sv
// Behavioural master for one two-wire bus.
// Assumes the bench resolves the open-drain data level and feeds it back.
`timescale 1ns/1ps
module rap_bus_master (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda_in,
  output logic     scl,
  output logic     sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Changes land just after an edge so the device never races them
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task start;
    sda_oe = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(1);
  endtask : start
  task stop;
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask : stop
  // Bit 0 of tx is the acknowledge slot; 1 leaves the line released
  task xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_oe = !tx[i];
      tick(4);
      scl = 1'b1;
      tick(4);
      rx[i] = sda_in;
      scl = 1'b0;
      tick(1);
    end
  endtask : xfer
endmodule : rap_bus_master

// ### verification/rap_top_props.sv
// Checker for the register access port, watching only the top ports.
// Assumes each bus clock phase lasts at least 4 clk and pins are sampled on clk.
`timescale 1ns/1ps
module rap_top_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Bus pins
  input wire logic       system_bus_clock_pin,
  input wire logic       system_bus_data_pin_in,
  input wire logic       system_bus_data_pin_oe,
  input wire logic       scaling_bus_clock_pin,
  input wire logic       scaling_bus_data_pin_in,
  input wire logic       scaling_bus_data_pin_oe,
  // Status
  input wire logic       system_bus_busy,
  input wire logic       voltage_scaling_bus_busy,
  input wire logic [7:0] master_voltage_enable_ff
);
  // ********
  // Framing
  // ********
  logic [3:0] pins_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins_ff <= 4'hf;
    end else begin
      pins_ff <= {system_bus_clock_pin, system_bus_data_pin_in, scaling_bus_clock_pin,
                  scaling_bus_data_pin_in};
    end
  end
  wire sys_hold  = system_bus_clock_pin && pins_ff[3];
  wire sys_start = sys_hold && pins_ff[2] && !system_bus_data_pin_in;
  wire sys_stop  = sys_hold && !pins_ff[2] && system_bus_data_pin_in;
  wire sr_hold   = scaling_bus_clock_pin && pins_ff[1];
  wire sr_start  = sr_hold && pins_ff[0] && !scaling_bus_data_pin_in;
  wire sr_stop   = sr_hold && !pins_ff[0] && scaling_bus_data_pin_in;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence sys_busy_rise;
    ##[1:4] system_bus_busy;
  endsequence
  sequence sys_busy_drop;
    ##[1:4] !system_bus_busy;
  endsequence

  a_start_sets_busy: assert property (sys_start |-> sys_busy_rise)
    else $error("system bus not busy after start");
  a_stop_clears_busy: assert property (sys_stop |-> sys_busy_drop)
    else $error("system bus still busy after stop");
  a_scaling_start_busy: assert property (sr_start |-> ##[1:4] voltage_scaling_bus_busy)
    else $error("scaling bus not busy after start");
  a_scaling_stop_idle: assert property (sr_stop |-> ##[1:4] !voltage_scaling_bus_busy)
    else $error("scaling bus still busy after stop");
  a_oe_moves_low: assert property ($changed(system_bus_data_pin_oe) |->
    !system_bus_clock_pin && $past(system_bus_clock_pin, 4))
    else $error("system data drive changed outside early clock low");
  a_scaling_oe_low: assert property ($changed(scaling_bus_data_pin_oe) |->
    !scaling_bus_clock_pin && $past(scaling_bus_clock_pin, 4))
    else $error("scaling data drive changed outside early clock low");
  a_idle_released: assert property (!system_bus_busy |-> !system_bus_data_pin_oe)
    else $error("data driven while bus idle");
  a_drive_holds: assert property ($rose(system_bus_data_pin_oe) |->
    system_bus_data_pin_oe [*5])
    else $error("data drive released too early");
  a_busy_ends_stop: assert property ($fell(system_bus_busy) |-> $past(sys_stop) ||
    $past(sys_stop, 2) || $past(sys_stop, 3) || $past(sys_stop, 4))
    else $error("busy dropped without stop");
  a_reg_in_frame: assert property ($changed(master_voltage_enable_ff) |->
    system_bus_busy || voltage_scaling_bus_busy)
    else $error("register changed outside a transfer");
endmodule : rap_top_props

bind rap_top rap_top_props u_props (
  .clk(clk), .rst_b(rst_b),
  .system_bus_clock_pin(system_bus_clock_pin), .system_bus_data_pin_in(system_bus_data_pin_in),
  .system_bus_data_pin_oe(system_bus_data_pin_oe),
  .scaling_bus_clock_pin(scaling_bus_clock_pin),
  .scaling_bus_data_pin_in(scaling_bus_data_pin_in),
  .scaling_bus_data_pin_oe(scaling_bus_data_pin_oe),
  .system_bus_busy(system_bus_busy), .voltage_scaling_bus_busy(voltage_scaling_bus_busy),
  .master_voltage_enable_ff(master_voltage_enable_ff)
);

// ### verification/rap_top_tb.sv
// Testbench for the register access port with two bus master models.
// Assumes the checker is bound to rap_top by its own file.
`timescale 1ns/1ps
module rap_top_tb import rap_pkg::*; ;
  logic       clk;
  logic       rst_b;
  logic       external_reset_input;
  logic [7:0] load_current;
  wire        sys_scl, sys_m_oe, sys_d_oe, sys_busy, sr_scl, sr_m_oe, sr_d_oe, sr_busy;
  wire  [7:0] mve;
  // Pull-ups hold released lines high
  wire        sys_sda = !(sys_m_oe || sys_d_oe);
  wire        sr_sda  = !(sr_m_oe || sr_d_oe);
  int         n_fail, samples_checked, cycles;

  rap_bus_master m_sys (.clk(clk), .sda_in(sys_sda), .scl(sys_scl), .sda_oe(sys_m_oe));
  rap_bus_master m_sr (.clk(clk), .sda_in(sr_sda), .scl(sr_scl), .sda_oe(sr_m_oe));
  rap_top dut (
    .clk(clk), .rst_b(rst_b),
    .system_bus_clock_pin(sys_scl), .system_bus_data_pin_in(sys_sda),
    .system_bus_data_pin_oe(sys_d_oe),
    .scaling_bus_clock_pin(sr_scl), .scaling_bus_data_pin_in(sr_sda),
    .scaling_bus_data_pin_oe(sr_d_oe),
    .external_reset_input(external_reset_input), .load_current(load_current),
    .system_bus_busy(sys_busy), .voltage_scaling_bus_busy(sr_busy),
    .master_voltage_enable_ff(mve)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The run needs about 8k cycles; the ceiling leaves a wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      test_done();
    end
  end

  // ********
  // Helpers
  // ********
  task automatic test_done;
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic st(input bit sr);
    if (sr) m_sr.start();
    else m_sys.start();
  endtask : st
  task automatic sp(input bit sr);
    if (sr) m_sr.stop();
    else m_sys.stop();
  endtask : sp
  task automatic x(input bit sr, input logic [8:0] tx, output logic [8:0] rx);
    if (sr) m_sr.xfer(tx, rx);
    else m_sys.xfer(tx, rx);
  endtask : x
  task automatic wb(input bit sr, input logic [7:0] b, input logic ack);
    logic [8:0] rx;
    x(sr, {b, 1'b1}, rx);
    check("ack", {7'h0, rx[0]}, {7'h0, !ack});
  endtask : wb
  task automatic wr(input bit sr, input logic [7:0] a, input logic [7:0] d);
    st(sr);
    wb(sr, {CHIP_ADDR, 1'b0}, 1'b1);
    wb(sr, a, 1'b1);
    wb(sr, d, 1'b1);
    sp(sr);
  endtask : wr
  task automatic rd(input bit sr, input logic [7:0] a, output logic [7:0] v);
    logic [8:0] r0, r1;
    st(sr);
    wb(sr, {CHIP_ADDR, 1'b0}, 1'b1);
    wb(sr, a, 1'b1);
    st(sr);
    wb(sr, {CHIP_ADDR, 1'b1}, 1'b1);
    x(sr, 9'h1fe, r0);
    x(sr, 9'h1ff, r1);
    sp(sr);
    check("repeat read", r1[8:1], r0[8:1]);
    v = r0[8:1];
  endtask : rd

  // ********
  // Scenarios
  // ********
  task automatic t_write_frame;
    logic [7:0] v;
    m_sys.start();
    check("busy", {7'h0, sys_busy}, 8'h01);
    wb(0, {CHIP_ADDR, 1'b0}, 1'b1);
    wb(0, ADDR_MASTER_VOLTAGE_ENABLE, 1'b1);
    wb(0, 8'ha5, 1'b1);
    m_sys.stop();
    check("idle", {7'h0, sys_busy}, 8'h00);
    check("mve", mve, 8'ha5);
    rd(0, ADDR_MASTER_VOLTAGE_ENABLE, v);
    check("readback", v, 8'ha5);
  endtask : t_write_frame
  task automatic t_auto_inc;
    logic [7:0] v;
    st(0);
    wb(0, {CHIP_ADDR, 1'b0}, 1'b1);
    wb(0, ADDR_FORCED_PULSE_WIDTH_SELECT, 1'b1);
    for (int i = 0; i < 3; i++) wb(0, 8'(8'h11 * (i + 1)), 1'b1);
    sp(0);
    for (int i = 0; i < 3; i++) begin
      rd(0, ADDR_FORCED_PULSE_WIDTH_SELECT + 8'(i), v);
      check("increment", v, 8'(8'h11 * (i + 1)));
    end
  endtask : t_auto_inc
  task automatic t_bad_addr;
    st(0);
    wb(0, {CHIP_ADDR ^ 7'h01, 1'b0}, 1'b0);
    wb(0, ADDR_MASTER_VOLTAGE_ENABLE, 1'b0);
    wb(0, 8'h00, 1'b0);
    sp(0);
    check("mve kept", mve, 8'ha5);
  endtask : t_bad_addr
  task automatic t_read_only;
    logic [7:0] v;
    wr(0, ADDR_PART_IDENTIFICATION, 8'hff);
    rd(0, ADDR_PART_IDENTIFICATION, v);
    check("part id", v, 8'h5a);
    wr(0, ADDR_LOAD_CURRENT_LOW, 8'h00);
    rd(0, ADDR_LOAD_CURRENT_LOW, v);
    check("load current", v, 8'h3c);
  endtask : t_read_only
  task automatic t_scaling;
    logic [7:0] v;
    external_reset_input = 1'b0;
    wr(1, ADDR_MASTER_VOLTAGE_ENABLE, 8'h5c);
    check("mve scaling", mve, 8'h5c);
    check("scaling idle", {7'h0, sr_busy}, 8'h00);
    rd(1, ADDR_MASTER_VOLTAGE_ENABLE, v);
    check("scaling read", v, 8'h5c);
    rd(0, ADDR_MASTER_VOLTAGE_ENABLE, v);
    check("system read", v, 8'h5c);
    external_reset_input = 1'b1;
  endtask : t_scaling
  task automatic t_restart;
    logic [7:0] v;
    st(0);
    wb(0, {CHIP_ADDR, 1'b0}, 1'b1);
    wb(0, ADDR_STARTUP_DELAY, 1'b1);
    st(0);
    wb(0, {CHIP_ADDR, 1'b0}, 1'b1);
    wb(0, ADDR_GENERAL_CONFIG, 1'b1);
    wb(0, 8'h77, 1'b1);
    sp(0);
    rd(0, ADDR_GENERAL_CONFIG, v);
    check("after restart", v, 8'h77);
    rd(0, ADDR_STARTUP_DELAY, v);
    check("untouched", v, REG_RESET_VALUE);
    // Read-modify-write keeps the bits it does not mean to touch
    rd(0, ADDR_GENERAL_CONFIG, v);
    wr(0, ADDR_GENERAL_CONFIG, v | 8'h80);
    rd(0, ADDR_GENERAL_CONFIG, v);
    check("modify", v, 8'hf7);
  endtask : t_restart

  initial begin
    rst_b = 1'b0;
    external_reset_input = 1'b1;
    load_current = 8'h3c;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    t_write_frame();
    t_auto_inc();
    t_bad_addr();
    t_read_only();
    t_scaling();
    t_restart();
    test_done();
  end
endmodule : rap_top_tb
